/* design/cio_pkg.sv */
// Package of constants for the call and indexed-operation executor.
package cio_pkg;

	// ----------------------------------------------------------------
	// Register map and fields
	// ----------------------------------------------------------------
	localparam logic [3:0] ADR_CTRL    = 4'h0;
	localparam logic [3:0] ADR_INSTR   = 4'h1;
	localparam logic [3:0] ADR_WORK    = 4'h2;
	localparam logic [3:0] ADR_FLAGS   = 4'h3;
	localparam logic [3:0] ADR_BANK    = 4'h4;
	localparam logic [3:0] ADR_PTR2    = 4'h5;
	localparam logic [3:0] ADR_PC      = 4'h6;
	localparam logic [3:0] ADR_STACK_TOP = 4'h7;
	localparam logic [3:0] ADR_SHADOW  = 4'h8;
	localparam logic [3:0] ADR_STATUS  = 4'h9;
	localparam logic [3:0] ADR_MEMWIN  = 4'hA;
	localparam int         CTRL_GO     = 0;
	localparam int         FLG_C       = 0;
	localparam int         FLG_DC      = 1;
	localparam int         FLG_Z       = 2;
	localparam int         FLG_OV      = 3;
	localparam int         FLG_N       = 4;

	// ----------------------------------------------------------------
	// Opcodes
	// ----------------------------------------------------------------
	localparam logic [6:0] OP_CALL1    = 7'h76;
	localparam logic [3:0] OP_WORD2    = 4'hF;
	localparam logic [5:0] OP_IADD     = 6'h09;
	localparam logic [3:0] OP_IBSET    = 4'h8;
	localparam logic [7:0] OP_IFILL    = 8'h68;
	localparam logic [7:0] FILL_VALUE  = 8'hFF;
	localparam logic [20:0] PC_STEP    = 21'h000004;
	localparam logic [20:0] PC_RESET   = 21'h000000;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int         PHASES      = 4;
	localparam int         DATA_DEPTH  = 256;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_Q1    = 3'b001,
		ST_Q2    = 3'b010,
		ST_Q3    = 3'b011,
		ST_Q4    = 3'b100,
		ST_NOP   = 3'b101
	} cio_state_t;

endpackage

/* design/cio_phase_gen.sv */
// Four-phase instruction cycle generator.
`timescale 1ns/1ns
module cio_phase_gen
	import cio_pkg::*;
#(
	parameter int N_PHASES = PHASES
) (
	input  wire logic       i_clk,
	input  wire logic       i_srst,
	input  wire logic       i_run,
	output logic      [1:0] o_phase,
	output logic            o_last
);
	if (N_PHASES != 4) begin : g_bad_phases
		$error("cio_phase_gen serves exactly four phases");
	end

	// Phase counter restarts with every instruction so Q1 always aligns with decode.
	always_ff @(posedge i_clk) begin
		if (i_srst || !i_run) begin
			o_phase <= 2'h0;
		end else begin
			o_phase <= o_phase + 2'h1;
		end
	end

	assign o_last = (o_phase == 2'h3);
endmodule

/* design/cio_alu.sv */
// Byte adder and flag generator for the indexed add.
`timescale 1ns/1ns
module cio_alu
	import cio_pkg::*;
(
	input  wire logic [7:0] i_a,
	input  wire logic [7:0] i_b,
	input  wire logic [4:0] i_flags,
	output logic      [7:0] o_sum,
	output logic      [4:0] o_flags
);
	wire [8:0] full_sum  = {1'b0, i_a} + {1'b0, i_b};
	wire [4:0] low_sum   = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
	wire       ovf       = (i_a[7] == i_b[7]) && (full_sum[7] != i_a[7]);

	assign o_sum = full_sum[7:0];

	// Flag positions come from the package so every user agrees on them.
	always_comb begin
		o_flags         = i_flags;
		o_flags[FLG_C]  = full_sum[8];
		o_flags[FLG_DC] = low_sum[4];
		o_flags[FLG_Z]  = (full_sum[7:0] == 8'h00);
		o_flags[FLG_OV] = ovf;
		o_flags[FLG_N]  = full_sum[7];
	end
endmodule

/* design/cio_core.sv */
// Executor for the two-word call and three indexed literal-offset instructions.
// Overview of operation
// - Call word one: 1110110, fast bit, k7..0.
// - Call word two: 1111 then k19..8.
// - Push PC plus four; literal to PC<20:1>.
// - Fast bit copies work, flags, bank shadows.
// - Cycle one: decode, read low, push.
// - Q4 reads high, writes PC; then nop cycle.
// - Indexed add: 001001, d, 0, offset.
// - d zero to work, one to memory.
// - Indexed bit set: 1000, bbb, 0, offset.
// - Set selected bit only, flags unchanged.
// - Indexed fill writes FFh, flags unchanged.
// - Instruction cycle is four phases.
`timescale 1ns/1ns
module cio_core
	import cio_pkg::*;
#(
	parameter int MEM_DEPTH = DATA_DEPTH
) (
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [5:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	output logic             o_busy
);
	if (MEM_DEPTH != 256) begin : g_bad_depth
		$error("cio_core data memory must hold 256 bytes");
	end

	// ----------------------------------------------------------------
	// Architectural state
	// ----------------------------------------------------------------
	cio_state_t  state;
	logic [31:0] instr;
	logic [7:0]  work;
	logic [4:0]  flags;
	logic [7:0]  bank_select_reg;
	logic [7:0]  index_pointer_two;
	logic [20:0] pc;
	logic [20:0] stack_top;
	logic [7:0]  work_shadow;
	logic [4:0]  flags_shadow;
	logic [7:0]  bank_sel_shadow;
	logic [7:0]  lit_low;
	logic [7:0]  data_mem [MEM_DEPTH];
	logic [7:0]  mem_addr_win;
	logic [3:0]  done_count;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire [15:0] word1    = instr[15:0];
	wire [15:0] word2    = instr[31:16];
	wire        is_call  = (word1[15:9] == OP_CALL1) && (word2[15:12] == OP_WORD2);
	wire        fast     = word1[8];
	wire        is_iadd  = (word1[15:10] == OP_IADD) && !word1[8];
	wire        dest_mem = word1[9];
	wire        is_ibset = (word1[15:12] == OP_IBSET) && !word1[8];
	wire [2:0]  bit_pos  = word1[11:9];
	wire        is_ifill = (word1[15:8] == OP_IFILL);
	wire [7:0]  eff_addr = index_pointer_two + word1[7:0];
	wire [7:0]  mem_rd   = data_mem[eff_addr];
	wire [19:0] call_lit = {word2[11:0], lit_low};
	wire [7:0]  bit_mask = 8'h01 << bit_pos;

	wire [7:0]  alu_sum;
	wire [4:0]  alu_flags;
	cio_alu u_alu (
		.i_a     (work),
		.i_b     (mem_rd),
		.i_flags (flags),
		.o_sum   (alu_sum),
		.o_flags (alu_flags)
	);

	wire [1:0] phase;
	wire       phase_last;
	wire       running = (state != ST_IDLE);
	cio_phase_gen u_phase (
		.i_clk   (i_clk),
		.i_srst  (i_srst),
		.i_run   (running),
		.o_phase (phase),
		.o_last  (phase_last)
	);

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	wire        wb_req   = i_wb_cyc && i_wb_stb && !o_wb_ack;
	wire        wb_wr    = wb_req && i_wb_we;
	wire [3:0]  reg_idx  = i_wb_adr[5:2];
	wire        wr_lo    = wb_wr && i_wb_sel[0];
	wire        wr_go    = wr_lo && (reg_idx == ADR_CTRL) && !running && i_wb_dat[CTRL_GO];
	wire        sw_wr    = wr_lo && !running;
	wire [31:0] rd_mux =
		(reg_idx == ADR_CTRL)   ? {31'h0, running} :
		(reg_idx == ADR_INSTR)  ? instr :
		(reg_idx == ADR_WORK)   ? {24'h0, work} :
		(reg_idx == ADR_FLAGS)  ? {27'h0, flags} :
		(reg_idx == ADR_BANK)   ? {24'h0, bank_select_reg} :
		(reg_idx == ADR_PTR2)   ? {24'h0, index_pointer_two} :
		(reg_idx == ADR_PC)     ? {11'h0, pc} :
		(reg_idx == ADR_STACK_TOP) ? {11'h0, stack_top} :
		(reg_idx == ADR_SHADOW) ? {3'h0, flags_shadow, bank_sel_shadow, work_shadow, 8'h00} :
		(reg_idx == ADR_STATUS) ? {24'h0, mem_addr_win} :
		(reg_idx == ADR_MEMWIN) ? {24'h0, data_mem[mem_addr_win]} : 32'h0;

	// Every access, mapped or not, is acknowledged in one cycle; unmapped reads return zero.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0;
		end else begin
			o_wb_ack <= wb_req;
			o_wb_dat <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	cio_state_t next_state;
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (wr_go) next_state = ST_Q1;
			end
			ST_Q1: next_state = ST_Q2;
			ST_Q2: next_state = ST_Q3;
			ST_Q3: next_state = ST_Q4;
			ST_Q4: next_state = is_call ? ST_NOP : ST_IDLE;
			ST_NOP: begin
				if (phase_last) next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// Busy comes from its own flop fed by the next state, so the pin needs no gate after it.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state  <= ST_IDLE;
			o_busy <= 1'b0;
		end else begin
			state  <= next_state;
			o_busy <= (next_state != ST_IDLE);
		end
	end

	// ----------------------------------------------------------------
	// Datapath
	// ----------------------------------------------------------------
	// Registers are only writable from the bus while idle, so an instruction never races software.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			instr             <= 32'h0;
			work              <= 8'h00;
			flags             <= 5'h00;
			bank_select_reg   <= 8'h00;
			index_pointer_two <= 8'h00;
			pc                <= PC_RESET;
			stack_top         <= PC_RESET;
			work_shadow       <= 8'h00;
			flags_shadow      <= 5'h00;
			bank_sel_shadow   <= 8'h00;
			lit_low           <= 8'h00;
			mem_addr_win      <= 8'h00;
		end else begin
			if (sw_wr && reg_idx == ADR_INSTR) instr <= i_wb_dat;
			if (sw_wr && reg_idx == ADR_WORK) work <= i_wb_dat[7:0];
			if (sw_wr && reg_idx == ADR_FLAGS) flags <= i_wb_dat[4:0];
			if (sw_wr && reg_idx == ADR_BANK) bank_select_reg <= i_wb_dat[7:0];
			if (sw_wr && reg_idx == ADR_PTR2) index_pointer_two <= i_wb_dat[7:0];
			if (sw_wr && reg_idx == ADR_PC) pc <= i_wb_dat[20:0];
			if (sw_wr && reg_idx == ADR_STATUS) mem_addr_win <= i_wb_dat[7:0];
			if (state == ST_Q2 && is_call) lit_low <= word1[7:0];
			if (state == ST_Q3 && is_call) begin
				stack_top <= pc + PC_STEP;
				if (fast) begin
					work_shadow     <= work;
					flags_shadow    <= flags;
					bank_sel_shadow <= bank_select_reg;
				end
			end
			if (state == ST_Q4 && is_call) pc <= {call_lit, 1'b0};
			if (state == ST_Q4 && is_iadd) begin
				flags <= alu_flags;
				if (!dest_mem) work <= alu_sum;
			end
		end
	end

	// Data memory: bus writes through the window while idle, instruction writes in Q4.
	always_ff @(posedge i_clk) begin
		if (state == ST_Q4 && is_iadd && dest_mem) begin
			data_mem[eff_addr] <= alu_sum;
		end else if (state == ST_Q4 && is_ibset) begin
			data_mem[eff_addr] <= mem_rd | bit_mask;
		end else if (state == ST_Q4 && is_ifill) begin
			data_mem[eff_addr] <= FILL_VALUE;
		end else if (sw_wr && reg_idx == ADR_MEMWIN) begin
			data_mem[mem_addr_win] <= i_wb_dat[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_srst || state == ST_IDLE) done_count <= 4'h0;
		else done_count <= done_count + 4'h1;
	end

	chk_call_push: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == ST_Q3 && is_call) |=> (stack_top == $past(pc) + PC_STEP))
		else $error("stack top not pc plus four");
	chk_call_target: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == ST_Q4 && is_call) |=> (pc == {word2[11:0], word1[7:0], 1'b0}))
		else $error("call target wrong");
	chk_call_length: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == ST_Q1 && is_call) |-> ##7 (state == ST_NOP) ##1 (state == ST_IDLE))
		else $error("call not two cycles");
	chk_fast_shadow: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == ST_Q3 && is_call && fast) |=> (work_shadow == $past(work) && bank_sel_shadow == $past(bank_select_reg)))
		else $error("shadow copy missing");
	chk_slow_shadow: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == ST_Q3 && is_call && !fast) |=> $stable(work_shadow))
		else $error("shadow changed without fast flag");
	chk_cycle_len: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == ST_Q1 && !is_call) |-> ##3 (state == ST_Q4) ##1 (state == ST_IDLE))
		else $error("single cycle not four phases");
	chk_bset_flags: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == ST_Q4 && (is_ibset || is_ifill)) |=> $stable(flags))
		else $error("flags changed by bit set or fill");
	chk_bset_bit: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == ST_Q4 && is_ibset) |=> data_mem[$past(eff_addr)] == ($past(mem_rd) | $past(bit_mask)))
		else $error("bit set result wrong");
	chk_fill_value: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == ST_Q4 && is_ifill) |=> data_mem[$past(eff_addr)] == FILL_VALUE)
		else $error("fill not all ones");
	chk_add_dest: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == ST_Q4 && is_iadd && !dest_mem) |=> (work == $past(alu_sum)))
		else $error("add result not in work");
	// A call spends eight clocks away from idle, so the count never passes eight.
	chk_run_bound: assert property (@(posedge i_clk) disable iff (i_srst)
		done_count <= 4'h8)
		else $error("instruction overran two cycles");

	// ----------------------------------------------------------------
	// Further datapath and sequencing checks
	// ----------------------------------------------------------------
	chk_fast_flags: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == ST_Q3 && is_call && fast) |=> (flags_shadow == $past(flags)))
		else $error("flags shadow copy missing");
	chk_slow_flags: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == ST_Q3 && is_call && !fast) |=> ($stable(flags_shadow) && $stable(bank_sel_shadow)))
		else $error("flags or bank shadow changed without fast flag");
	chk_low_latch: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == ST_Q2 && is_call) |=> (lit_low == $past(instr[7:0])))
		else $error("low literal not taken in second phase");
	chk_add_zero: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == ST_Q4 && is_iadd) |=> (flags[FLG_Z] == (8'($past(work) + $past(mem_rd)) == 8'h00)))
		else $error("add zero flag wrong");
	chk_add_carry: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == ST_Q4 && is_iadd) |=> (flags[FLG_C] == ((9'($past(work)) + 9'($past(mem_rd))) > 9'h0FF)))
		else $error("add carry flag wrong");
	chk_add_neg: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == ST_Q4 && is_iadd) |=> (flags[FLG_N] == (8'($past(work) + $past(mem_rd)) >= 8'h80)))
		else $error("add negative flag wrong");
	chk_add_mem: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == ST_Q4 && is_iadd && dest_mem) |=> (data_mem[$past(eff_addr)] == 8'($past(work) + $past(mem_rd))))
		else $error("add result not in memory");
	chk_add_work_keep: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == ST_Q4 && is_iadd && dest_mem) |=> $stable(work))
		else $error("work changed by add to memory");
	chk_op_work_keep: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == ST_Q4 && (is_ibset || is_ifill)) |=> $stable(work))
		else $error("work changed by bit set or fill");
	chk_nop_phase: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == ST_Q4 && is_call) |=> (phase == 2'h0))
		else $error("nop cycle not aligned to first phase");
	chk_go_start: assert property (@(posedge i_clk) disable iff (i_srst)
		wr_go |=> (state == ST_Q1))
		else $error("go did not start first phase");
	chk_pc_hold: assert property (@(posedge i_clk) disable iff (i_srst)
		(running && !is_call) |=> $stable(pc))
		else $error("pc moved by a non-call instruction");
	chk_stack_hold: assert property (@(posedge i_clk) disable iff (i_srst)
		(running && !is_call) |=> $stable(stack_top))
		else $error("stack top moved by a non-call instruction");
	chk_ack_pulse: assert property (@(posedge i_clk) disable iff (i_srst)
		o_wb_ack |=> !o_wb_ack)
		else $error("bus acknowledge longer than one cycle");
endmodule

/* sim/call_and_indexed_ops_test.sv */
// Self-checking testbench for the call and indexed-operation executor.
`timescale 1ns/1ns
module call_and_indexed_ops_test;
	import cio_pkg::*;

	// ----------------------------------------------------------------
	// Clock, reset and bus signals
	// ----------------------------------------------------------------
	logic        i_clk;
	logic        i_srst;
	logic        wb_cyc;
	logic        wb_stb;
	logic        wb_we;
	logic [5:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [31:0] wb_wdat;
	logic [31:0] wb_rdat;
	logic        wb_ack;
	logic        busy_spare;
	int          err_total;
	int          cmp_count;
	logic [31:0] rd;
	logic [7:0]  acc;

	cio_core cio_core_inst (
		.i_clk    (i_clk),
		.i_srst   (i_srst),
		.i_wb_cyc (wb_cyc),
		.i_wb_stb (wb_stb),
		.i_wb_we  (wb_we),
		.i_wb_adr (wb_adr),
		.i_wb_sel (wb_sel),
		.i_wb_dat (wb_wdat),
		.o_wb_dat (wb_rdat),
		.o_wb_ack (wb_ack),
		.o_busy   (busy_spare)
	);

	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Reads see the pre-edge ack because all design updates land in the NBA region.
	task automatic wb_xfer(input logic we, input logic [3:0] idx, input logic [31:0] wd, output logic [31:0] rdat);
		int n;
		@(posedge i_clk);
		wb_cyc  <= 1'b1;
		wb_stb  <= 1'b1;
		wb_we   <= we;
		wb_adr  <= {idx, 2'b00};
		wb_wdat <= wd;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
			$display("ERROR bus ack expected 1 seen timeout");
		end
		rdat = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we  <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
		logic [31:0] dummy;
		wb_xfer(1'b1, idx, wd, dummy);
	endtask

	task automatic rd_chk(input string name, input logic [3:0] idx, input logic [31:0] exp);
		wb_xfer(1'b0, idx, 32'h00000000, rd);
		check(name, exp, rd);
	endtask

	task automatic set_mem(input logic [7:0] a, input logic [7:0] v);
		wr(ADR_STATUS, {24'h000000, a});
		wr(ADR_MEMWIN, {24'h000000, v});
	endtask

	task automatic mem_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
		wr(ADR_STATUS, {24'h000000, a});
		rd_chk(name, ADR_MEMWIN, {24'h000000, exp});
	endtask

	// Three clocks after go a one-cycle op is done while a call is still in its nop cycle.
	task automatic run_instr(input logic [31:0] instr, input logic late_busy);
		int n;
		wr(ADR_INSTR, instr);
		wr(ADR_CTRL, 32'h00000001);
		check("busy pin", 32'h00000001, {31'h00000000, busy_spare});
		repeat (3) @(posedge i_clk);
		rd_chk("busy late", ADR_CTRL, {31'h00000000, late_busy});
		n = 0;
		do begin
			wb_xfer(1'b0, ADR_CTRL, 32'h00000000, rd);
			n++;
		end while (rd[CTRL_GO] !== 1'b0 && n < 20);
		check("run done", 32'h00000000, {31'h00000000, rd[CTRL_GO]});
		check("busy pin idle", 32'h00000000, {31'h00000000, busy_spare});
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_reset();
		rd_chk("pc reset", ADR_PC, 32'h00000000);
		rd_chk("stack top reset", ADR_STACK_TOP, 32'h00000000);
		wr(4'hF, 32'hFFFFFFFF);
		rd_chk("unmapped", 4'hF, 32'h00000000);
	endtask

	task automatic test_call();
		wr(ADR_WORK, 32'h0000005A);
		wr(ADR_FLAGS, 32'h00000013);
		wr(ADR_BANK, 32'h0000000C);
		wr(ADR_PC, 32'h00000100);
		wr(ADR_INSTR, 32'hFABCEDDE);
		wr(ADR_CTRL, 32'h00000001);
		wr(ADR_WORK, 32'h000000EE);
		rd_chk("call busy", ADR_CTRL, 32'h00000001);
		repeat (10) @(posedge i_clk);
		rd_chk("busy write", ADR_WORK, 32'h0000005A);
		rd_chk("call stack top", ADR_STACK_TOP, 32'h00000104);
		rd_chk("call pc", ADR_PC, 32'h001579BC);
		rd_chk("shadow", ADR_SHADOW, 32'h130C5A00);
		wr(ADR_WORK, 32'h00000077);
		run_instr(32'hF000EC12, 1'b1);
		rd_chk("call2 stack top", ADR_STACK_TOP, 32'h001579C0);
		rd_chk("call2 pc", ADR_PC, 32'h00000024);
		rd_chk("no shadow", ADR_SHADOW, 32'h130C5A00);
	endtask

	task automatic test_add();
		wr(ADR_PTR2, 32'h000000F0);
		set_mem(8'h10, 8'h88);
		wr(ADR_WORK, 32'h00000088);
		run_instr(32'h00002420, 1'b0);
		rd_chk("add w", ADR_WORK, 32'h00000010);
		rd_chk("add flags", ADR_FLAGS, 32'h0000000B);
		mem_chk("add mem", 8'h10, 8'h88);
		set_mem(8'h10, 8'h80);
		wr(ADR_WORK, 32'h00000080);
		run_instr(32'h00002620, 1'b0);
		rd_chk("add2 w", ADR_WORK, 32'h00000080);
		rd_chk("add2 flags", ADR_FLAGS, 32'h0000000D);
		mem_chk("add2 mem", 8'h10, 8'h00);
	endtask

	task automatic test_bitset_fill();
		set_mem(8'h15, 8'h00);
		acc = 8'h00;
		for (int b = 0; b < 8; b++) begin
			run_instr({16'h0000, 16'h8025 | (16'(b) << 9)}, 1'b0);
			acc = acc | (8'h01 << b);
			mem_chk("bit set", 8'h15, acc);
		end
		set_mem(8'h20, 8'h12);
		run_instr(32'h00006830, 1'b0);
		mem_chk("fill", 8'h20, FILL_VALUE);
		rd_chk("flags kept", ADR_FLAGS, 32'h0000000D);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		err_total = 0;
		cmp_count = 0;
		i_srst    = 1'b1;
		wb_cyc    = 1'b0;
		wb_stb    = 1'b0;
		wb_we     = 1'b0;
		wb_adr    = 6'h00;
		wb_sel    = 4'hF;
		wb_wdat   = 32'h00000000;
		repeat (8) @(posedge i_clk);
		i_srst <= 1'b0;
		test_reset();
		test_call();
		test_add();
		test_bitset_fill();
		stop_test();
	end

	// The whole run needs a few hundred clocks, so this limit is generous.
	initial begin
		#400000;
		err_total++;
		$display("ERROR watchdog expected finish seen timeout");
		stop_test();
	end
endmodule
